// file: design/lcdpbm_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-low reset
// Notes:   Read data comes straight from a register
`timescale 1ns/100ps
module lcdpbm_fifo #(
  parameter int unsigned WIDTH = 17,  // Entry width
  parameter int unsigned DEPTH = 4,   // Number of entries
  parameter int unsigned AW    = 2    // Pointer width, log2 of DEPTH
) (
  input  wire logic             mclk_i,     // System clock
  input  wire logic             rst_n_i,    // Async reset, active low
  input  wire logic             in_valid_i, // Producer has an entry
  output logic                  in_ready_o, // Room for an entry
  input  wire logic [WIDTH-1:0] in_data_i,  // Entry to store
  output logic                  out_valid_o,// Head entry is valid
  input  wire logic             out_ready_i,// Consumer takes head
  output logic [WIDTH-1:0]      out_data_o  // Head entry
);

  // ---------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];   // Entry storage
  logic [AW-1:0]    wr_ptr_q;        // Next write slot
  logic [AW-1:0]    rd_ptr_q;        // Next slot to present
  logic [AW:0]      cnt_q;           // Entries held, incl. output reg
  logic             push;            // Entry accepted
  logic             pop;             // Head taken
  logic [AW:0]      mem_cnt;         // Entries waiting in memory

  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  // Entries in memory not yet moved into the output register
  assign mem_cnt = cnt_q - {{AW{1'b0}}, out_valid_o};

  // Full while all entries are held
  assign in_ready_o = (cnt_q < (AW+1)'(DEPTH));

  // Write side
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  // Memory array, no reset needed
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Occupancy count
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Output register loads from memory when empty or drained
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr_q    <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if ((!out_valid_o || pop) && (mem_cnt != '0)) begin
      out_data_o  <= mem_q[rd_ptr_q];
      out_valid_o <= 1'b1;
      rd_ptr_q    <= rd_ptr_q + 1'b1;
    end else if (pop) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule : lcdpbm_fifo

// file: design/lcdpbm_pkg.sv
// Purpose: Shared constants for the display parallel bus master
// Assumes: 100 MHz mclk_i, single clock domain
// Notes:   Widths and timing settings fixed at build time
package lcdpbm_pkg;

  // ---------------------------------------------------------------
  // Build settings
  // ---------------------------------------------------------------
  localparam int unsigned BUS_WIDTH       = 16;  // 8 or 16
  localparam int unsigned RD_LOW_DEFAULT  = 10;  // Read strobe low cycles
  localparam int unsigned RD_HIGH_DEFAULT = 10;  // Read strobe high cycles
  localparam int unsigned RD_LOW_MIN      = 2;   // Least low width
  localparam int unsigned RD_HIGH_MIN     = 1;   // Least high width
  localparam int unsigned CNT_MAX         = 255; // Largest width setting
  localparam int unsigned CNT_W           = 8;   // Width of cycle counter
  localparam int unsigned WR_LOW_CYCLES   = 1;   // Write strobe low cycles
  localparam int unsigned FIFO_DEPTH      = 4;   // Write queue entries
  localparam int unsigned FIFO_AW         = 2;   // Queue pointer width
  localparam int unsigned CMD_W           = 17;  // d/c bit plus data

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;  // Data outputs after reset
  localparam logic [CNT_W-1:0] RST_CNT = 8'h00; // Counter after reset

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LCDPBM_IDLE   = 3'b000,  // Waiting for work
    LCDPBM_WSTRB  = 3'b001,  // Write strobe low
    LCDPBM_WDONE  = 3'b010,  // Write strobe released
    LCDPBM_RLOW   = 3'b011,  // Read strobe low
    LCDPBM_RHIGH  = 3'b100   // Read strobe high recovery
  } lcdpbm_state_t;

endpackage : lcdpbm_pkg

// file: design/lcdpbm_top.sv
// Purpose: Parallel bus master for an external display controller
// Assumes: 100 MHz mclk_i; controller answers within read low width
// Notes:   Writes are posted into a 4-entry queue; reads wait for it
//
// Overview of operation
// - Each transaction holds one address bit throughout
// - Data/command output high data, low command
// - Write strobe low exactly one clock
// - Read strobe low 2..255 cycles, default 10
// - Read strobe high 1..255 cycles, default 10
// - Sample read bus one cycle before release
// - Build setting picks 8 or 16 bit bus
// - Write data driven on output bus
// - Read data taken from input bus
// - Output enable controls data bus pins
// - Active-low chip select marks each transaction
// - Only the matching strobe is asserted
// - Single clock, read inputs need no synchroniser
// - Writes queued; stall while queue full
// - Read runs after all posted writes finish
`timescale 1ns/100ps
module lcdpbm_top #(
  parameter logic [7:0] RD_LOW  = 8'h0a,  // Read low width, 2..255
  parameter logic [7:0] RD_HIGH = 8'h0a   // Read high width, 1..255
) (
  input  wire logic        mclk_i,             // System clock
  input  wire logic        rst_n_i,            // Async reset, active low
  // Write request port
  input  wire logic        wr_valid_i,         // Write request
  output logic             wr_ready_o,         // Queue has room
  input  wire logic        wr_dc_i,            // 1 data, 0 command
  input  wire logic [15:0] wr_data_i,          // Write data
  // Read request port
  input  wire logic        rd_valid_i,         // Read request
  output logic             rd_ready_o,         // Read request taken
  input  wire logic        rd_dc_i,            // 1 data, 0 command
  output logic             rd_done_o,          // Read result pulse
  output logic [15:0]      rd_data_o,          // Read result
  // Display bus pins
  output logic             cs_n_o,             // Chip select, low active
  output logic             wr_n_o,             // Write strobe, low active
  output logic             rd_n_o,             // Read strobe, low active
  output logic             dc_o,               // Data/command select
  output logic             oe_o,               // Data bus drive enable
  output logic [7:0]       write_bus_low_byte_o,  // Output data low
  output logic [7:0]       write_bus_high_byte_o, // Output data high
  input  wire logic [7:0]  read_bus_low_byte_i,   // Input data low
  input  wire logic [7:0]  read_bus_high_byte_i   // Input data high
);

  // ---------------------------------------------------------------
  // Local signals
  // ---------------------------------------------------------------
  localparam bit WIDE = (lcdpbm_pkg::BUS_WIDTH == 16); // 16-bit mode

  lcdpbm_pkg::lcdpbm_state_t state_q;           // Sequencer state
  logic [lcdpbm_pkg::CNT_W-1:0] cnt_q;          // Strobe width count
  logic [lcdpbm_pkg::CMD_W-1:0] q_data;         // Queue head
  logic                         q_valid;        // Queue head valid
  logic                         q_pop;          // Take queue head
  logic                         rd_pend_q;      // Read accepted, waiting
  logic                         rd_dc_q;        // Held read address bit
  logic [lcdpbm_pkg::CMD_W-1:0] wr_entry;       // Entry pushed to queue
  logic [7:0]                   hi_in;          // Upper lane, masked
  logic [7:0]                   hi_out;         // Upper write lane
  logic                         wq_push_q;      // Entry pushed last cycle
  logic                         rd_go;          // Read may start now

  // Upper byte lane exists only in 16-bit mode
  assign hi_in = WIDE ? read_bus_high_byte_i : 8'h00;
  assign hi_out = WIDE ? q_data[15:8] : 8'h00;

  assign wr_entry = {wr_dc_i, wr_data_i};

  // A fresh entry sits in queue memory one cycle before the head is
  // valid; holding the read off that cycle keeps posted writes first
  assign rd_go = rd_pend_q && !wr_valid_i && !wq_push_q;

  // Remember a push so the read start sees the hidden entry
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wq_push_q <= 1'b0;
    end else begin
      wq_push_q <= wr_valid_i && wr_ready_o;
    end
  end

  // Queue head taken when the sequencer starts a write from idle
  assign q_pop = (state_q == lcdpbm_pkg::LCDPBM_IDLE) && q_valid;

  // ---------------------------------------------------------------
  // Write queue
  // ---------------------------------------------------------------
  // Back-pressure on the request side stalls new writes
  lcdpbm_fifo #(
    .WIDTH (lcdpbm_pkg::CMD_W),
    .DEPTH (lcdpbm_pkg::FIFO_DEPTH),
    .AW    (lcdpbm_pkg::FIFO_AW)
  ) u_wq (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wr_entry),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_data)
  );

  // ---------------------------------------------------------------
  // Read request acceptance
  // ---------------------------------------------------------------
  // One read at a time; ready pulses for the cycle it is taken
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_q  <= 1'b0;
      rd_dc_q    <= 1'b0;
      rd_ready_o <= 1'b0;
    end else begin
      rd_ready_o <= 1'b0;
      if (rd_valid_i && !rd_pend_q && !rd_ready_o) begin
        rd_pend_q  <= 1'b1;       // Captured, waits for queue drain
        rd_dc_q    <= rd_dc_i;
        rd_ready_o <= 1'b1;
      end else if (state_q == lcdpbm_pkg::LCDPBM_RLOW &&
                   cnt_q == lcdpbm_pkg::RST_CNT) begin
        rd_pend_q  <= 1'b0;       // Read finished on the bus
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  // Writes always win over a pending read so posted writes finish
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= lcdpbm_pkg::LCDPBM_IDLE;
      cnt_q   <= lcdpbm_pkg::RST_CNT;
    end else begin
      case (state_q)
        lcdpbm_pkg::LCDPBM_IDLE: begin
          if (q_valid) begin
            state_q <= lcdpbm_pkg::LCDPBM_WSTRB;
          end else if (rd_go) begin
            state_q <= lcdpbm_pkg::LCDPBM_RLOW;
            cnt_q   <= RD_LOW - 8'h01;
          end
        end
        lcdpbm_pkg::LCDPBM_WSTRB: begin
          state_q <= lcdpbm_pkg::LCDPBM_WDONE;
        end
        lcdpbm_pkg::LCDPBM_WDONE: begin
          state_q <= lcdpbm_pkg::LCDPBM_IDLE;
        end
        lcdpbm_pkg::LCDPBM_RLOW: begin
          if (cnt_q == lcdpbm_pkg::RST_CNT) begin
            state_q <= lcdpbm_pkg::LCDPBM_RHIGH;
            cnt_q   <= RD_HIGH - 8'h01;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        lcdpbm_pkg::LCDPBM_RHIGH: begin
          if (cnt_q == lcdpbm_pkg::RST_CNT) begin
            state_q <= lcdpbm_pkg::LCDPBM_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= lcdpbm_pkg::LCDPBM_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Registered strobes: outputs change at the same edge as the state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      oe_o   <= 1'b0;
      dc_o   <= 1'b0;
    end else begin
      case (state_q)
        lcdpbm_pkg::LCDPBM_IDLE: begin
          if (q_valid) begin
            cs_n_o <= 1'b0;
            wr_n_o <= 1'b0;
            oe_o   <= 1'b1;
            dc_o   <= q_data[16];
          end else if (rd_go) begin
            cs_n_o <= 1'b0;
            rd_n_o <= 1'b0;
            oe_o   <= 1'b0;
            dc_o   <= rd_dc_q;
          end else begin
            cs_n_o <= 1'b1;
            oe_o   <= 1'b0;
          end
        end
        lcdpbm_pkg::LCDPBM_WSTRB: begin
          wr_n_o <= 1'b1;                 // one-cycle low
        end
        lcdpbm_pkg::LCDPBM_WDONE: begin
          cs_n_o <= 1'b1;                 // released after strobe
          oe_o   <= 1'b0;
        end
        lcdpbm_pkg::LCDPBM_RLOW: begin
          if (cnt_q == lcdpbm_pkg::RST_CNT) begin
            rd_n_o <= 1'b1;
          end
        end
        lcdpbm_pkg::LCDPBM_RHIGH: begin
          cs_n_o <= 1'b1;                 // released one cycle after strobe
        end
        default: begin
          cs_n_o <= 1'b1;
          wr_n_o <= 1'b1;
          rd_n_o <= 1'b1;
          oe_o   <= 1'b0;
        end
      endcase
    end
  end

  // Write data loaded with the strobe and held until next write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_bus_low_byte_o  <= lcdpbm_pkg::RST_BYTE;
      write_bus_high_byte_o <= lcdpbm_pkg::RST_BYTE;
    end else if (q_pop) begin
      write_bus_low_byte_o  <= q_data[7:0];
      write_bus_high_byte_o <= hi_out;
    end
  end

  // ---------------------------------------------------------------
  // Read capture
  // ---------------------------------------------------------------
  // Strobe is low while state is RLOW with registered pins, so the
  // last RLOW cycle (count zero) is the final low cycle; sampling
  // one cycle earlier means count one, or the first cycle at width 2
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 16'h0000;
      rd_done_o <= 1'b0;
    end else begin
      rd_done_o <= 1'b0;
      if (state_q == lcdpbm_pkg::LCDPBM_RLOW &&
          cnt_q == 8'h01) begin
        rd_data_o <= {hi_in, read_bus_low_byte_i};
        rd_done_o <= 1'b1;
      end
    end
  end

endmodule : lcdpbm_top

// file: testbench/lcdpbm_chk.sv
// Purpose: Timing checks on the display bus pins
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into lcdpbm_top, sees only its ports
`timescale 1ns/100ps
module lcdpbm_chk #(
  parameter logic [7:0] RD_LOW  = 8'h0a, // Read strobe low width
  parameter logic [7:0] RD_HIGH = 8'h0a  // Read strobe high width
) (
  input wire logic       mclk_i,              // System clock
  input wire logic       rst_n_i,             // Async reset, active low
  input wire logic       wr_ready_o,          // Queue has room
  input wire logic       rd_done_o,           // Read result pulse
  input wire logic       cs_n_o,              // Chip select
  input wire logic       wr_n_o,              // Write strobe
  input wire logic       rd_n_o,              // Read strobe
  input wire logic       dc_o,                // Data/command
  input wire logic       oe_o,                // Bus drive enable
  input wire logic [7:0] write_bus_low_byte_o // Output data low
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] lo_cnt_q;  // Read strobe low cycles so far
  logic [7:0] hi_cnt_q;  // Read strobe high cycles so far
  logic       rd_seen_q; // A read strobe has ended

  // Measure low and high spells of the read strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_cnt_q  <= 8'h00;
      hi_cnt_q  <= 8'h00;
      rd_seen_q <= 1'b0;
    end else begin
      lo_cnt_q <= rd_n_o ? 8'h00 : lo_cnt_q + 8'h01;
      if (!rd_n_o) begin
        hi_cnt_q <= 8'h00;
      end else if (hi_cnt_q != 8'hff) begin
        hi_cnt_q <= hi_cnt_q + 8'h01;
      end
      if ($rose(rd_n_o)) begin
        rd_seen_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_wr_pulse; $fell(wr_n_o) |=> wr_n_o; endproperty
  property p_rd_low; $rose(rd_n_o) |-> lo_cnt_q == RD_LOW; endproperty
  property p_rd_high;
    $fell(rd_n_o) && rd_seen_q |-> hi_cnt_q >= RD_HIGH;
  endproperty
  property p_done_pos; rd_done_o |-> !rd_n_o ##1 rd_n_o; endproperty
  property p_one_strb; !wr_n_o |-> rd_n_o && oe_o; endproperty
  property p_oe_rd; !rd_n_o |-> !oe_o; endproperty
  property p_cs_cov; (!wr_n_o || !rd_n_o) |-> !cs_n_o; endproperty
  property p_dc_hold; !rd_n_o && !$past(rd_n_o) |-> $stable(dc_o);
  endproperty
  property p_wr_hold;
    $rose(wr_n_o) |-> !cs_n_o && oe_o && $stable(dc_o)
      && $stable(write_bus_low_byte_o);
  endproperty

  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe width wrong");
  a_rd_low: assert property (p_rd_low)
    else $error("read strobe low width wrong");
  a_rd_high: assert property (p_rd_high)
    else $error("read strobe high width short");
  a_done_pos: assert property (p_done_pos)
    else $error("read result not in last low cycle");
  a_one_strb: assert property (p_one_strb)
    else $error("write strobe with read strobe or no drive");
  a_oe_rd: assert property (p_oe_rd)
    else $error("bus driven during read");
  a_cs_cov: assert property (p_cs_cov)
    else $error("strobe without chip select");
  a_dc_hold: assert property (p_dc_hold)
    else $error("address moved during read strobe");
  a_wr_hold: assert property (p_wr_hold)
    else $error("write cycle ended early");

  c_write: cover property ($fell(wr_n_o));
  c_read: cover property (rd_done_o);
  c_full: cover property (!wr_ready_o);
endmodule : lcdpbm_chk

bind lcdpbm_top lcdpbm_chk #(.RD_LOW(RD_LOW), .RD_HIGH(RD_HIGH)) u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_ready_o(wr_ready_o),
  .rd_done_o(rd_done_o), .cs_n_o(cs_n_o), .wr_n_o(wr_n_o),
  .rd_n_o(rd_n_o), .dc_o(dc_o), .oe_o(oe_o),
  .write_bus_low_byte_o(write_bus_low_byte_o));

// file: testbench/lcdpbm_disp_model.sv
// Purpose: Display controller seen across the parallel bus
// Assumes: Answers reads after a set access delay
// Notes:   Released bus lines toggle every cycle
`timescale 1ns/100ps
module lcdpbm_disp_model (
  input  wire logic        mclk_i,    // System clock
  input  wire logic        rst_n_i,   // Async reset, active low
  input  wire logic        cs_n_i,    // Chip select
  input  wire logic        wr_n_i,    // Write strobe
  input  wire logic        rd_n_i,    // Read strobe
  input  wire logic        dc_i,      // Data/command
  input  wire logic        oe_i,      // Master drives bus
  input  wire logic [15:0] wdata_i,   // Master output lanes
  input  wire logic [15:0] rd_word_i, // Word to answer reads
  input  wire logic [7:0]  acc_dly_i, // Access delay in cycles
  output logic      [15:0] bus_o,     // Resolved data bus
  output logic      [16:0] last_wr_o, // Last write seen
  output int               wr_cnt_o,  // Writes seen
  output int               rd_wcnt_o, // Writes before last read
  output logic             rd_dc_o    // Address of last read
);
  logic [7:0]  acc_q;  // Cycles since read strobe fell
  logic [15:0] last_q; // Bus level last cycle
  logic        rd_n_q; // Read strobe last cycle

  // Resolve the shared bus from both drivers
  always_comb begin
    if (oe_i) begin
      bus_o = wdata_i;
    end else if (!cs_n_i && !rd_n_i && acc_q >= acc_dly_i) begin
      bus_o = rd_word_i;
    end else begin
      bus_o = ~last_q;
    end
  end

  // Log writes and read starts
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q     <= 8'h00;
      last_q    <= 16'h0000;
      rd_n_q    <= 1'b1;
      last_wr_o <= 17'h00000;
      wr_cnt_o  <= 0;
      rd_wcnt_o <= 0;
      rd_dc_o   <= 1'b0;
    end else begin
      acc_q  <= rd_n_i ? 8'h00 : acc_q + 8'h01;
      last_q <= bus_o;
      rd_n_q <= rd_n_i;
      if (!wr_n_i && !cs_n_i) begin
        last_wr_o <= {dc_i, bus_o};
        wr_cnt_o  <= wr_cnt_o + 1;
      end
      if (!rd_n_i && rd_n_q && !cs_n_i) begin
        rd_dc_o   <= dc_i;
        rd_wcnt_o <= wr_cnt_o;
      end
    end
  end
endmodule : lcdpbm_disp_model

// file: testbench/lcdpbm_tb_top.sv
// Purpose: Self-checking bench for the display bus master
// Assumes: 100 MHz clock, inputs driven at falling edge
// Notes:   Read widths shortened to keep the run brief
`timescale 1ns/100ps
module lcdpbm_tb_top;
  localparam logic [7:0] RD_LOW  = 8'h04; // Read low width
  localparam logic [7:0] RD_HIGH = 8'h03; // Read high width
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr_valid_i = 1'b0;
  logic        wr_dc_i = 1'b0;
  logic [15:0] wr_data_i = 16'h0000;
  logic        rd_valid_i = 1'b0;
  logic        rd_dc_i = 1'b0;
  logic [15:0] rd_word = 16'h0000; // Model read answer
  logic [7:0]  acc_dly = 8'h00;    // Model access delay
  logic        wr_ready_o, rd_ready_o, rd_done_o, cs_n_o, wr_n_o;
  logic        rd_n_o, dc_o, oe_o, rd_dc, full_seen;
  logic [7:0]  wlo, whi;
  logic [15:0] rd_data_o, bus;
  logic [16:0] last_wr;
  int          wr_cnt, rd_wcnt, error_cnt, tests_run, wr_total, cyc, n;

  always #5 mclk_i = ~mclk_i;

  lcdpbm_top #(.RD_LOW(RD_LOW), .RD_HIGH(RD_HIGH)) uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_valid_i(wr_valid_i),
    .wr_ready_o(wr_ready_o), .wr_dc_i(wr_dc_i), .wr_data_i(wr_data_i),
    .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o), .rd_dc_i(rd_dc_i),
    .rd_done_o(rd_done_o), .rd_data_o(rd_data_o), .cs_n_o(cs_n_o),
    .wr_n_o(wr_n_o), .rd_n_o(rd_n_o), .dc_o(dc_o), .oe_o(oe_o),
    .write_bus_low_byte_o(wlo), .write_bus_high_byte_o(whi),
    .read_bus_low_byte_i(bus[7:0]), .read_bus_high_byte_i(bus[15:8]));

  lcdpbm_disp_model u_disp (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_o), .wr_n_i(wr_n_o),
    .rd_n_i(rd_n_o), .dc_i(dc_o), .oe_i(oe_o), .wdata_i({whi, wlo}),
    .rd_word_i(rd_word), .acc_dly_i(acc_dly), .bus_o(bus),
    .last_wr_o(last_wr), .wr_cnt_o(wr_cnt), .rd_wcnt_o(rd_wcnt),
    .rd_dc_o(rd_dc));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Post one write; valid stays up for a following push
  task automatic push(input logic dc, input logic [15:0] d);
    wr_valid_i = 1'b1;
    wr_dc_i    = dc;
    wr_data_i  = d;
    if (wr_ready_o !== 1'b1) full_seen = 1'b1;
    for (n = 0; n < 100 && wr_ready_o !== 1'b1; n++) @(negedge mclk_i);
    @(negedge mclk_i);
    wr_total++;
  endtask : push

  task automatic wait_writes();
    wr_valid_i = 1'b0;
    for (n = 0; n < 200 && wr_cnt != wr_total; n++) @(negedge mclk_i);
  endtask : wait_writes

  // Idle pin levels while reset holds
  task automatic test_reset();
    chk(32'({cs_n_o, wr_n_o, rd_n_o, oe_o, wr_ready_o}), 32'h1d);
  endtask : test_reset

  // Command then data write, each checked on the bus
  task automatic test_write();
    push(1'b0, 16'h1234);
    wait_writes();
    chk(32'(last_wr), 32'h01234);
    push(1'b1, 16'hbeef);
    wait_writes();
    chk(32'(last_wr), 32'h1beef);
  endtask : test_write

  // Burst past the queue depth, then drain
  task automatic test_burst();
    full_seen = 1'b0;
    for (int i = 0; i < 8; i++) push(i[0], 16'hc000 | 16'(i));
    wait_writes();
    chk(32'(full_seen), 32'h1);
    chk(32'(wr_cnt), 32'(wr_total));
    chk(32'(last_wr), 32'h1c007);
  endtask : test_burst

  // Read right behind two posted writes
  task automatic test_read(input logic dc, input logic [15:0] w,
                           input logic [7:0] acc);
    rd_word = w;
    acc_dly = acc;
    push(1'b1, ~w);
    push(1'b0, w);
    wr_valid_i = 1'b0;
    rd_valid_i = 1'b1;
    rd_dc_i    = dc;
    for (n = 0; n < 200 && rd_ready_o !== 1'b1; n++) @(negedge mclk_i);
    rd_valid_i = 1'b0;
    for (n = 0; n < 300 && rd_done_o !== 1'b1; n++) @(negedge mclk_i);
    chk(32'(rd_data_o), 32'(w));
    chk(32'(rd_wcnt), 32'(wr_total));
    chk(32'(rd_dc), 32'(dc));
    repeat (8) @(negedge mclk_i);
  endtask : test_read

  // Write and read taken at one edge: the write must reach the bus first
  task automatic test_order();
    rd_word    = 16'h5a5a;
    acc_dly    = 8'h00;
    wr_valid_i = 1'b1;
    wr_dc_i    = 1'b1;
    wr_data_i  = 16'h0f0f;
    rd_valid_i = 1'b1;
    rd_dc_i    = 1'b1;
    @(negedge mclk_i);
    wr_valid_i = 1'b0;
    rd_valid_i = 1'b0;
    wr_total++;
    for (n = 0; n < 300 && rd_done_o !== 1'b1; n++) @(negedge mclk_i);
    chk(32'(rd_wcnt), 32'(wr_total));
    chk(32'(rd_data_o), 32'h5a5a);
    repeat (8) @(negedge mclk_i);
  endtask : test_order

  // Cut a hung run short
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(negedge mclk_i);
    test_reset();
    rst_n_i = 1'b1;
    test_write();
    test_burst();
    test_read(1'b0, 16'ha55a, 8'h00);
    test_read(1'b1, 16'h3cc3, RD_LOW - 8'h02);
    test_order();
    wrap_up();
  end
endmodule : lcdpbm_tb_top
